// ===== rtl/scd_regs.svh
`ifndef SCD_REGS_SVH
`define SCD_REGS_SVH

// Three-level strap codes as delivered by the pad comparators.
`define SCD_LVL_LOW 2'h0
`define SCD_LVL_MID 2'h1
`define SCD_LVL_HIGH 2'h2

// Reset values of the serial-mode settings.
`define SCD_RST_BUS_EQ 2'h1
`define SCD_RST_BUS_DE 2'h1
`define SCD_RST_BUS_TERM 2'h1
`define SCD_RST_BUS_LANE 2'h1

// Reset values of the latched straps and of the datapath settings.
`define SCD_RST_STRAP_LVL 2'h1
`define SCD_RST_CFG_EQ 2'h1
`define SCD_RST_CFG_DE 2'h1
`define SCD_RST_CFG_TERM 2'h1

// Field positions in the slave address bits.
`define SCD_ADDR_BIT_LOW 0
`define SCD_ADDR_BIT_HIGH 1

`endif

// ===== rtl/scd_pkg.sv
package scd_pkg;

  typedef enum logic [1:0] {
    SCD_LVL_LOW = 2'h0,
    SCD_LVL_MID = 2'h1,
    SCD_LVL_HIGH = 2'h2
  } scd_level_t;

  typedef enum logic [1:0] {
    SCD_EQ_FIXED_7P5 = 2'h0,
    SCD_EQ_ADAPTIVE = 2'h1,
    SCD_EQ_FIXED_14 = 2'h2
  } scd_eq_t;

  typedef enum logic [1:0] {
    SCD_DE_MINUS2 = 2'h0,
    SCD_DE_ZERO = 2'h1,
    SCD_DE_RSVD = 2'h2
  } scd_deemph_t;

  typedef enum logic [1:0] {
    SCD_TERM_RSVD = 2'h0,
    SCD_TERM_AUTO = 2'h1,
    SCD_TERM_NONE = 2'h2
  } scd_term_t;

  typedef enum logic [1:0] {
    SCD_LANE_SWAP = 2'h0,
    SCD_LANE_NORMAL = 2'h1,
    SCD_LANE_INVERT = 2'h2
  } scd_lane_t;

  typedef enum logic [3:0] {
    SCD_ST_RESET = 4'h1,
    SCD_ST_PDOWN = 4'h2,
    SCD_ST_LATCH = 4'h4,
    SCD_ST_RUN = 4'h8
  } scd_state_t;

  typedef struct packed {
    scd_level_t rx_gain;
    scd_level_t deemph;
    scd_level_t term;
    scd_level_t lane;
    logic upper_addr;
    logic serial_mode;
  } scd_strap_t;

  typedef struct packed {
    scd_eq_t eq;
    scd_deemph_t deemph;
    scd_term_t term;
    scd_lane_t lane;
  } scd_bus_cfg_t;

  typedef struct packed {
    scd_eq_t eq;
    scd_deemph_t deemph;
    scd_term_t term;
    logic tx_term_on;
    logic lane_swap;
    logic lane_invert;
  } scd_cfg_t;

endpackage

// ===== rtl/scd_strap_latch.sv
`timescale 1ns/1ns
`include "scd_regs.svh"
module scd_strap_latch (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Control
  input wire logic clear,
  input wire logic load,
  // Data
  input wire scd_pkg::scd_strap_t strap_in,
  output scd_pkg::scd_strap_t strap_ff
);

  scd_pkg::scd_strap_t nxt_strap;
  scd_pkg::scd_strap_t rst_strap;

  // Holds the decoded straps from the latch point until the next reset.
  always_comb begin
    rst_strap = '{rx_gain: scd_pkg::scd_level_t'(`SCD_RST_STRAP_LVL),
                  deemph: scd_pkg::scd_level_t'(`SCD_RST_STRAP_LVL),
                  term: scd_pkg::scd_level_t'(`SCD_RST_STRAP_LVL),
                  lane: scd_pkg::scd_level_t'(`SCD_RST_STRAP_LVL),
                  upper_addr: 1'h0, serial_mode: 1'h0};
    nxt_strap = strap_ff;
    if (clear) begin
      nxt_strap = rst_strap;
    end else if (load) begin
      nxt_strap = strap_in;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      strap_ff <= rst_strap;
    end else begin
      strap_ff <= nxt_strap;
    end
  end

endmodule // scd_strap_latch

// ===== rtl/scd_top.sv
// What this block does
// - Operation enable low holds power-down; high allows normal operation.
// - Falling operation enable resets device; pin defaults high by pull-up.
// - Activity detect low disables detector; input terminations connected throughout normal operation.
// - In normal operation activity detect high enables detector; standby whenever no valid input clock.
// - Control mode select high picks serial bus, low picks pin straps.
// - In strap mode straps win; bus writes change no strap function.
// - In serial mode de-emphasis comes from the configuration bus.
// - Gain strap low fixed 7.5 dB, open adaptive, high fixed 14 dB.
// - In serial mode gain pin is a two-level address bit.
// - Upper address strap gives high address bit; board leaves it open otherwise.
// - Termination strap high means no termination; low is reserved.
// - Termination strap open selects termination automatically by data rate.
// - Lane inversion strap high inverts receive polarity, retimer operation only.
// - Lane inversion strap low swaps lane order; open passes lanes normally.
`timescale 1ns/1ns
`include "scd_regs.svh"
module scd_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Control pins
  input wire logic op_enable,
  input wire logic activity_detect_enable,
  input wire logic control_mode_select,
  // Three-level straps, already resolved to level codes, and the two-level upper address strap
  input wire scd_pkg::scd_level_t rx_gain_strap,
  input wire scd_pkg::scd_level_t deemph_strap,
  input wire scd_pkg::scd_level_t output_termination_strap,
  input wire scd_pkg::scd_level_t rx_lane_inversion_strap,
  input wire logic upper_address_strap,
  // Serial configuration bus write port
  input wire logic bus_wr_valid,
  input wire scd_pkg::scd_bus_cfg_t bus_wr_data,
  // Datapath status
  input wire logic input_clock_valid,
  input wire logic rate_above_2g,
  input wire logic retimer_mode,
  // Datapath settings
  output scd_pkg::scd_cfg_t cfg_ff,
  output logic power_down_ff,
  output logic standby_ff,
  output logic sig_detect_on_ff,
  output logic input_term_on_ff,
  output logic serial_mode_ff,
  output logic [1:0] slave_addr_ff,
  output logic device_reset_ff
);

  scd_pkg::scd_state_t state_ff;
  scd_pkg::scd_state_t nxt_state;
  logic op_enable_prev_ff;
  logic nxt_op_enable_prev;
  logic op_fall;
  logic strap_clear;
  logic strap_load;
  scd_pkg::scd_strap_t strap_in;
  scd_pkg::scd_strap_t strap_ff;
  scd_pkg::scd_bus_cfg_t bus_cfg_ff;
  scd_pkg::scd_bus_cfg_t nxt_bus_cfg;
  scd_pkg::scd_cfg_t nxt_cfg;
  logic nxt_power_down;
  logic nxt_standby;
  logic nxt_sig_detect_on;
  logic nxt_input_term_on;
  logic nxt_serial_mode;
  logic [1:0] nxt_slave_addr;
  logic nxt_device_reset;
  logic running;

  function automatic logic lvl_is(input scd_pkg::scd_level_t lvl, input logic [1:0] code);
    lvl_is = (lvl == code);
  endfunction

  function automatic scd_pkg::scd_term_t term_decode(input scd_pkg::scd_level_t lvl);
    if (lvl_is(lvl, `SCD_LVL_HIGH)) begin
      term_decode = scd_pkg::SCD_TERM_NONE;
    end else if (lvl_is(lvl, `SCD_LVL_LOW)) begin
      term_decode = scd_pkg::SCD_TERM_RSVD;
    end else begin
      term_decode = scd_pkg::SCD_TERM_AUTO;
    end
  endfunction

  always_comb begin
    strap_in.rx_gain = rx_gain_strap;
    strap_in.deemph = deemph_strap;
    strap_in.term = output_termination_strap;
    strap_in.lane = rx_lane_inversion_strap;
    strap_in.upper_addr = upper_address_strap;
    strap_in.serial_mode = control_mode_select;
  end

  // Operation enable edge and the device state.
  always_comb begin
    nxt_op_enable_prev = op_enable;
    op_fall = op_enable_prev_ff && !op_enable;
    nxt_state = state_ff;
    case (state_ff)
      scd_pkg::SCD_ST_RESET: begin
        nxt_state = op_enable ? scd_pkg::SCD_ST_LATCH : scd_pkg::SCD_ST_PDOWN;
      end
      scd_pkg::SCD_ST_PDOWN: begin
        if (op_enable) begin
          nxt_state = scd_pkg::SCD_ST_LATCH;
        end
      end
      scd_pkg::SCD_ST_LATCH: begin
        nxt_state = op_enable ? scd_pkg::SCD_ST_RUN : scd_pkg::SCD_ST_PDOWN;
      end
      scd_pkg::SCD_ST_RUN: begin
        if (!op_enable) begin
          nxt_state = scd_pkg::SCD_ST_PDOWN;
        end
      end
      default: begin
        nxt_state = scd_pkg::SCD_ST_RESET;
      end
    endcase
    strap_clear = op_fall;
    strap_load = (state_ff == scd_pkg::SCD_ST_LATCH) && op_enable;
    running = (state_ff == scd_pkg::SCD_ST_RUN);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_ff <= scd_pkg::SCD_ST_RESET;
      op_enable_prev_ff <= 1'h1;
    end else begin
      state_ff <= nxt_state;
      op_enable_prev_ff <= nxt_op_enable_prev;
    end
  end

  scd_strap_latch u_strap_latch (
    .core_clk(core_clk),
    .srst(srst),
    .clear(strap_clear),
    .load(strap_load),
    .strap_in(strap_in),
    .strap_ff(strap_ff)
  );

  // Serial bus settings, written only in serial mode.
  always_comb begin
    nxt_bus_cfg = bus_cfg_ff;
    if (op_fall) begin
      nxt_bus_cfg.eq = scd_pkg::scd_eq_t'(`SCD_RST_BUS_EQ);
      nxt_bus_cfg.deemph = scd_pkg::scd_deemph_t'(`SCD_RST_BUS_DE);
      nxt_bus_cfg.term = scd_pkg::scd_term_t'(`SCD_RST_BUS_TERM);
      nxt_bus_cfg.lane = scd_pkg::scd_lane_t'(`SCD_RST_BUS_LANE);
    end else if (bus_wr_valid && running && strap_ff.serial_mode) begin
      nxt_bus_cfg = bus_wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      bus_cfg_ff.eq <= scd_pkg::scd_eq_t'(`SCD_RST_BUS_EQ);
      bus_cfg_ff.deemph <= scd_pkg::scd_deemph_t'(`SCD_RST_BUS_DE);
      bus_cfg_ff.term <= scd_pkg::scd_term_t'(`SCD_RST_BUS_TERM);
      bus_cfg_ff.lane <= scd_pkg::scd_lane_t'(`SCD_RST_BUS_LANE);
    end else begin
      bus_cfg_ff <= nxt_bus_cfg;
    end
  end

  // Settings seen by the datapath.
  always_comb begin
    nxt_serial_mode = strap_ff.serial_mode;
    if (strap_ff.serial_mode) begin
      nxt_cfg.eq = bus_cfg_ff.eq;
      nxt_cfg.deemph = bus_cfg_ff.deemph;
      nxt_cfg.term = bus_cfg_ff.term;
      nxt_cfg.lane_swap = (bus_cfg_ff.lane == scd_pkg::SCD_LANE_SWAP);
      nxt_cfg.lane_invert = (bus_cfg_ff.lane == scd_pkg::SCD_LANE_INVERT) && retimer_mode;
    end else begin
      nxt_cfg.eq = scd_pkg::scd_eq_t'(strap_ff.rx_gain);
      nxt_cfg.deemph = scd_pkg::scd_deemph_t'(strap_ff.deemph);
      nxt_cfg.term = term_decode(strap_ff.term);
      nxt_cfg.lane_swap = lvl_is(strap_ff.lane, `SCD_LVL_LOW);
      nxt_cfg.lane_invert = lvl_is(strap_ff.lane, `SCD_LVL_HIGH) && retimer_mode;
    end
    nxt_cfg.tx_term_on = (nxt_cfg.term == scd_pkg::SCD_TERM_AUTO) && rate_above_2g;
    nxt_slave_addr = 2'h0;
    if (strap_ff.serial_mode) begin
      nxt_slave_addr[`SCD_ADDR_BIT_LOW] = lvl_is(strap_ff.rx_gain, `SCD_LVL_HIGH);
      nxt_slave_addr[`SCD_ADDR_BIT_HIGH] = strap_ff.upper_addr;
    end
    nxt_power_down = !running;
    nxt_sig_detect_on = running && activity_detect_enable;
    nxt_standby = running && activity_detect_enable && !input_clock_valid;
    nxt_input_term_on = !(activity_detect_enable && !input_clock_valid) && running;
    nxt_device_reset = op_fall;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_ff <= '{eq: scd_pkg::scd_eq_t'(`SCD_RST_CFG_EQ),
                  deemph: scd_pkg::scd_deemph_t'(`SCD_RST_CFG_DE),
                  term: scd_pkg::scd_term_t'(`SCD_RST_CFG_TERM),
                  tx_term_on: 1'h0, lane_swap: 1'h0, lane_invert: 1'h0};
      power_down_ff <= 1'h1;
      standby_ff <= 1'h0;
      sig_detect_on_ff <= 1'h0;
      input_term_on_ff <= 1'h0;
      serial_mode_ff <= 1'h0;
      slave_addr_ff <= 2'h0;
      device_reset_ff <= 1'h0;
    end else begin
      cfg_ff <= nxt_cfg;
      power_down_ff <= nxt_power_down;
      standby_ff <= nxt_standby;
      sig_detect_on_ff <= nxt_sig_detect_on;
      input_term_on_ff <= nxt_input_term_on;
      serial_mode_ff <= nxt_serial_mode;
      slave_addr_ff <= nxt_slave_addr;
      device_reset_ff <= nxt_device_reset;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_fall;
    op_enable_prev_ff && !op_enable;
  endsequence

  sequence s_rise_latch;
    (state_ff == scd_pkg::SCD_ST_LATCH) && op_enable;
  endsequence

  AST_PDOWN_LOW: assert property (!op_enable ##1 !op_enable |=> power_down_ff)
    else $error("power-down not shown while enable low");
  AST_FALL_RESET: assert property (s_fall |=> device_reset_ff ##1 power_down_ff)
    else $error("falling enable did not reset device");
  AST_DETECT_OFF: assert property (
    running && !activity_detect_enable |=> input_term_on_ff && !standby_ff)
    else $error("terminations dropped with detector disabled");
  AST_STANDBY: assert property (
    running && activity_detect_enable && !input_clock_valid |=> standby_ff && !input_term_on_ff)
    else $error("no standby without valid clock");
  AST_STRAP_HOLD: assert property (
    running && !strap_ff.serial_mode && bus_wr_valid |=> $stable(bus_cfg_ff))
    else $error("bus write changed strap mode settings");
  AST_DEEMPH: assert property (
    !strap_ff.serial_mode && strap_ff.deemph == scd_pkg::SCD_LVL_LOW
    |=> cfg_ff.deemph == scd_pkg::SCD_DE_MINUS2)
    else $error("de-emphasis strap low not decoded");
  AST_EQ_HIGH: assert property (
    !strap_ff.serial_mode && strap_ff.rx_gain == scd_pkg::SCD_LVL_HIGH
    |=> cfg_ff.eq == scd_pkg::SCD_EQ_FIXED_14)
    else $error("gain strap high not decoded");
  AST_TERM_NONE: assert property (
    !strap_ff.serial_mode && strap_ff.term == scd_pkg::SCD_LVL_HIGH
    |=> cfg_ff.term == scd_pkg::SCD_TERM_NONE && !cfg_ff.tx_term_on)
    else $error("termination strap high not decoded");
  AST_LANE_SWAP: assert property (
    !strap_ff.serial_mode && strap_ff.lane == scd_pkg::SCD_LVL_LOW
    |=> cfg_ff.lane_swap && !cfg_ff.lane_invert)
    else $error("lane swap strap low not decoded");
  AST_LATCH: assert property (s_rise_latch |=> strap_ff == $past(strap_in))
    else $error("straps not latched on leaving power-down");

endmodule // scd_top

// ===== test/scd_board_model.sv
`timescale 1ns/1ns
module scd_board_model (
  // Clock
  input wire logic core_clk,
  // Straps and mode pin
  output scd_pkg::scd_level_t rx_gain_strap,
  output scd_pkg::scd_level_t deemph_strap,
  output scd_pkg::scd_level_t output_termination_strap,
  output scd_pkg::scd_level_t rx_lane_inversion_strap,
  output logic upper_address_strap,
  output logic control_mode_select,
  // Serial configuration host
  output logic bus_wr_valid,
  output scd_pkg::scd_bus_cfg_t bus_wr_data
);
  // Each strap is tied high, tied low or left open by the board.
  task automatic set_straps(input logic [1:0] lvl, input logic serial, input logic addr);
    rx_gain_strap = scd_pkg::scd_level_t'(lvl);
    deemph_strap = scd_pkg::scd_level_t'(lvl);
    output_termination_strap = scd_pkg::scd_level_t'(lvl);
    rx_lane_inversion_strap = scd_pkg::scd_level_t'(lvl);
    control_mode_select = serial;
    // The upper address pin is left open in strap mode, so its pull-down wins.
    upper_address_strap = serial & addr;
  endtask

  // One write per cycle; the data lines turn over once the host lets go.
  task automatic bus_write(input scd_pkg::scd_bus_cfg_t d, input logic last);
    bus_wr_valid = 1'b1;
    bus_wr_data = d;
    @(negedge core_clk);
    if (last) begin
      bus_wr_valid = 1'b0;
      bus_wr_data = scd_pkg::scd_bus_cfg_t'(~d);
    end
  endtask

  initial begin
    set_straps(2'h1, 1'b0, 1'b0);
    bus_wr_valid = 1'b0;
    bus_wr_data = scd_pkg::scd_bus_cfg_t'(8'h55);
  end
endmodule // scd_board_model

// ===== test/scd_top_tb_top.sv
`timescale 1ns/1ns
module scd_top_tb_top;
  logic core_clk;
  logic srst;
  logic op_enable;
  logic activity_detect_enable;
  logic input_clock_valid;
  logic rate_above_2g;
  logic retimer_mode;
  logic control_mode_select;
  logic upper_address_strap;
  logic bus_wr_valid;
  scd_pkg::scd_level_t rx_gain_strap;
  scd_pkg::scd_level_t deemph_strap;
  scd_pkg::scd_level_t output_termination_strap;
  scd_pkg::scd_level_t rx_lane_inversion_strap;
  scd_pkg::scd_bus_cfg_t bus_wr_data;
  scd_pkg::scd_cfg_t cfg_ff;
  scd_pkg::scd_cfg_t exp_cfg;
  logic power_down_ff;
  logic standby_ff;
  logic sig_detect_on_ff;
  logic input_term_on_ff;
  logic serial_mode_ff;
  logic [1:0] slave_addr_ff;
  logic device_reset_ff;
  int err_total;
  int total_checks;
  int n;

  scd_board_model board_u (.core_clk(core_clk), .rx_gain_strap(rx_gain_strap),
    .deemph_strap(deemph_strap), .output_termination_strap(output_termination_strap),
    .rx_lane_inversion_strap(rx_lane_inversion_strap),
    .upper_address_strap(upper_address_strap), .control_mode_select(control_mode_select),
    .bus_wr_valid(bus_wr_valid), .bus_wr_data(bus_wr_data));

  scd_top dut_u (.core_clk(core_clk), .srst(srst), .op_enable(op_enable),
    .activity_detect_enable(activity_detect_enable),
    .control_mode_select(control_mode_select), .rx_gain_strap(rx_gain_strap),
    .deemph_strap(deemph_strap), .output_termination_strap(output_termination_strap),
    .rx_lane_inversion_strap(rx_lane_inversion_strap),
    .upper_address_strap(upper_address_strap), .bus_wr_valid(bus_wr_valid),
    .bus_wr_data(bus_wr_data), .input_clock_valid(input_clock_valid),
    .rate_above_2g(rate_above_2g), .retimer_mode(retimer_mode), .cfg_ff(cfg_ff),
    .power_down_ff(power_down_ff), .standby_ff(standby_ff),
    .sig_detect_on_ff(sig_detect_on_ff), .input_term_on_ff(input_term_on_ff),
    .serial_mode_ff(serial_mode_ff), .slave_addr_ff(slave_addr_ff),
    .device_reset_ff(device_reset_ff));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask

  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Drops the enable pin, raises it again and waits a bounded time for start-up.
  task automatic power_cycle();
    op_enable = 1'b0;
    cyc(2);
    op_enable = 1'b1;
    n = 0;
    while (power_down_ff !== 1'b0 && n < 10) begin
      cyc(1);
      n++;
    end
    if (power_down_ff !== 1'b0) begin
      err_total++;
      final_report();
    end
    cyc(1);
  endtask

  initial begin
    err_total = 0;
    total_checks = 0;
    srst = 1'b1;
    op_enable = 1'b1;
    activity_detect_enable = 1'b0;
    input_clock_valid = 1'b1;
    rate_above_2g = 1'b1;
    retimer_mode = 1'b1;
    cyc(4);
    chk("power_down", 9'(power_down_ff), 9'h001);
    chk("cfg", cfg_ff, 9'h0a8);
    srst = 1'b0;
    for (int i = 0; i < 3; i++) begin
      board_u.set_straps(i[1:0], 1'b0, 1'b1);
      power_cycle();
      exp_cfg.eq = scd_pkg::scd_eq_t'(i[1:0]);
      exp_cfg.deemph = scd_pkg::scd_deemph_t'(i[1:0]);
      exp_cfg.term = scd_pkg::scd_term_t'(i[1:0]);
      exp_cfg.tx_term_on = (i == 1);
      exp_cfg.lane_swap = (i == 0);
      exp_cfg.lane_invert = (i == 2);
      chk("cfg", cfg_ff, exp_cfg);
      chk("serial_mode", 9'(serial_mode_ff), 9'h000);
      chk("slave_addr", 9'(slave_addr_ff), 9'h000);
    end
    rate_above_2g = 1'b0;
    retimer_mode = 1'b0;
    cyc(2);
    chk("lane_invert", 9'(cfg_ff.lane_invert), 9'h000);
    retimer_mode = 1'b1;
    board_u.set_straps(2'h1, 1'b0, 1'b0);
    power_cycle();
    chk("tx_term_on", 9'(cfg_ff.tx_term_on), 9'h000);
    rate_above_2g = 1'b1;
    cyc(2);
    chk("tx_term_on", 9'(cfg_ff.tx_term_on), 9'h001);
    board_u.set_straps(2'h0, 1'b1, 1'b1);
    board_u.bus_write(8'h88, 1'b1);
    cyc(3);
    chk("cfg", cfg_ff, 9'h0ac);
    board_u.set_straps(2'h2, 1'b1, 1'b1);
    power_cycle();
    chk("serial_mode", 9'(serial_mode_ff), 9'h001);
    chk("slave_addr", 9'(slave_addr_ff), 9'h003);
    board_u.bus_write(8'h88, 1'b1);
    cyc(2);
    chk("cfg", cfg_ff, 9'h112);
    board_u.bus_write(8'h88, 1'b0);
    board_u.bus_write(8'h16, 1'b1);
    cyc(2);
    chk("cfg", cfg_ff, 9'h02d);
    input_clock_valid = 1'b0;
    cyc(2);
    chk("standby", 9'({standby_ff, input_term_on_ff, sig_detect_on_ff}), 9'h002);
    activity_detect_enable = 1'b1;
    cyc(2);
    chk("standby", 9'({standby_ff, input_term_on_ff, sig_detect_on_ff}), 9'h005);
    input_clock_valid = 1'b1;
    cyc(2);
    chk("standby", 9'({standby_ff, input_term_on_ff, sig_detect_on_ff}), 9'h003);
    board_u.set_straps(2'h1, 1'b1, 1'b0);
    power_cycle();
    chk("slave_addr", 9'(slave_addr_ff), 9'h000);
    op_enable = 1'b0;
    n = 0;
    while (device_reset_ff !== 1'b1 && n < 3) begin
      cyc(1);
      n++;
    end
    chk("device_reset", 9'(device_reset_ff), 9'h001);
    cyc(1);
    chk("device_reset", 9'(device_reset_ff), 9'h000);
    cyc(4);
    chk("power_down", 9'(power_down_ff), 9'h001);
    chk("cfg", {3'h0, cfg_ff[8:3]}, 9'h015);
    final_report();
  end
endmodule // scd_top_tb_top
